// ### design/scp_command_parser.v
// Command interpreter for serial, CAN-rate and restart commands
//
// Overview of operation
// - Data-length code 0..3 gives 5..8 bits
// - Stop code 0 one bit, 1 two
// - Parity code 0 none, 1 odd, 2 even
// - Checksum code turns command checksum checking off/on
// - Error-response code suppresses or permits error replies
// - Rate pair 00..0B maps 110 to 115200 bps
// - Valid serial config saved, then restart, no reply
// - CAN rate command: code plus rate 0..4
// - Valid CAN rate saved, then restart
// - Valid restart command restarts the unit
// - Rejection reply: question mark, code, carriage return
// - Error replies only when error responses enabled
// - Unknown header gives error code 1
// - Only frame, status, clear, config, restart headers
// - Wrong command length gives error code 2
// - Checksum mismatch gives error code 3 when enabled
// - Incomplete command gives code 5; never code 4
// - Run indicator flashes while CAN transmit fails
// - Carriage return ends every command string
// - Checksum: byte sum before CR, two hex chars
`timescale 1ns/1ns
`default_nettype none
`include "scp_defs.vh"

module scp_command_parser #(
  parameter [22:0] TIMEOUT_CYCLES = `SCP_TIMEOUT_CYC,
  parameter [22:0] FLASH_CYCLES   = `SCP_FLASH_CYC
) (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire       rxValid,
  input  wire [7:0] rxData,
  output reg        txValid,
  output reg  [7:0] txData,
  input  wire       txReady,
  output reg  [3:0] serialRateCode,
  output reg  [1:0] dataBitsCode,
  output reg        twoStopBits,
  output reg  [1:0] parityMode,
  output reg        checksumEnable,
  output reg        errorResponseEnable,
  output reg  [2:0] canRateCode,
  output reg        nvSaveReq,
  output reg        nvSaveCan,
  input  wire       nvSaveDone,
  output reg        restartReq,
  output reg        frameCmdValid,
  output reg  [7:0] frameCmdHead,
  output reg  [5:0] frameCmdLen,
  input  wire       canTxFail,
  output reg        runIndicator
);

  localparam [2:0] ST_RX   = 3'h0;
  localparam [2:0] ST_EVAL = 3'h1;
  localparam [2:0] ST_ERRQ = 3'h2;
  localparam [2:0] ST_ERRC = 3'h3;
  localparam [2:0] ST_ERRR = 3'h4;
  localparam [2:0] ST_NV   = 3'h5;
  localparam [2:0] ST_RST  = 3'h6;

  // Hex digit to {valid, value}; both cases accepted
  function [4:0] hexVal;
    input [7:0] c;
    begin
      if (c >= `SCP_CH_0 && c <= `SCP_CH_9)
        hexVal = {1'b1, c[3:0]};
      else if ((c >= `SCP_CH_UA && c <= `SCP_CH_UF) || (c >= `SCP_CH_LA && c <= `SCP_CH_LF))
        hexVal = {1'b1, c[3:0] + 4'h9};
      else
        hexVal = 5'h00;
    end
  endfunction

  reg [7:0]  cmdBuf [0:`SCP_BUF_DEPTH-1];
  reg [5:0]  rxCount;
  reg        overflow;
  reg [7:0]  runSum;
  reg [2:0]  state;
  reg [7:0]  errCode;
  reg [22:0] idleCount;
  reg [22:0] flashCount;

  // Evaluation results, decoded from the held buffer
  reg [7:0]  next_errCode;
  reg        isFrame;
  reg        isSerCfg;
  reg        isCanCfg;
  reg        isRestart;
  reg [5:0]  bodyLen;
  reg [5:0]  wantLen;
  reg [7:0]  bodySum;
  reg [4:0]  chkHi;
  reg [4:0]  chkLo;
  reg [4:0]  dlc;
  reg [4:0] fRateHi, fRateLo, fData, fStop, fPar, fChk, fErr, fCan;
  reg        fieldsOk;
  reg [4:0]  idxLast;
  reg [4:0]  idxPrev;

  always @* begin
    next_errCode = 8'h00;
    isFrame      = 1'b0;
    isSerCfg     = 1'b0;
    isCanCfg     = 1'b0;
    isRestart    = 1'b0;
    wantLen      = 6'h00;
    fieldsOk     = 1'b1;
    idxLast      = rxCount[4:0] - 5'h01;
    idxPrev      = rxCount[4:0] - 5'h02;
    chkHi        = hexVal(cmdBuf[idxPrev]);
    chkLo        = hexVal(cmdBuf[idxLast]);
    // Checksum pair sits just before CR and is left out of the sum
    bodyLen      = checksumEnable ? rxCount - `SCP_CHK_CHARS : rxCount;
    bodySum      = checksumEnable ? runSum - cmdBuf[idxLast] - cmdBuf[idxPrev] : runSum;
    fRateHi      = hexVal(cmdBuf[2]);
    fRateLo      = hexVal(cmdBuf[3]);
    fData        = hexVal(cmdBuf[4]);
    fStop        = hexVal(cmdBuf[5]);
    fPar         = hexVal(cmdBuf[6]);
    fChk         = hexVal(cmdBuf[7]);
    fErr         = hexVal(cmdBuf[8]);
    fCan         = hexVal(cmdBuf[2]);
    dlc          = hexVal(cmdBuf[`SCP_POS_DLC_STD]);
    // Header recognition
    case (cmdBuf[0])
      `SCP_CH_LT: begin
        isFrame = 1'b1;
        wantLen = `SCP_LEN_STD + {1'b0, dlc[3:0], 1'b0};
      end
      `SCP_CH_LE: begin
        isFrame = 1'b1;
        dlc     = hexVal(cmdBuf[`SCP_POS_DLC_EXT]);
        wantLen = `SCP_LEN_EXT + {1'b0, dlc[3:0], 1'b0};
      end
      `SCP_CH_UT: begin
        isFrame = 1'b1;
        wantLen = `SCP_LEN_STD;
      end
      `SCP_CH_UE: begin
        isFrame = 1'b1;
        dlc     = hexVal(cmdBuf[`SCP_POS_DLC_EXT]);
        wantLen = `SCP_LEN_EXT;
      end
      `SCP_CH_US, `SCP_CH_UC: begin
        isFrame = 1'b1;
        dlc     = {1'b1, 4'h0};
        wantLen = `SCP_LEN_ONE;
      end
      `SCP_CH_UP: begin
        isSerCfg = (cmdBuf[1] == `SCP_CH_0);
        isCanCfg = (cmdBuf[1] == `SCP_CH_1);
        wantLen  = isSerCfg ? `SCP_LEN_SERCFG : `SCP_LEN_CANCFG;
      end
      `SCP_CH_UR: begin
        isRestart = (cmdBuf[1] == `SCP_CH_UA);
        wantLen   = `SCP_LEN_RESTART;
      end
      default: wantLen = 6'h00;
    endcase
    // Field range checks; a bad frame length digit also counts here
    if (isFrame)
      fieldsOk = dlc[4] && dlc[3:0] <= `SCP_DLC_MAX;
    else if (isSerCfg)
      fieldsOk = fRateHi[4] && fRateLo[4] && fData[4] && fStop[4] && fPar[4] && fChk[4]
                 && fErr[4] && {fRateHi[3:0], fRateLo[3:0]} <= `SCP_SER_RATE_MAX
                 && fData[3:0] <= `SCP_DBITS_MAX && fStop[3:0] <= `SCP_STOP_MAX
                 && fPar[3:0] <= `SCP_PAR_MAX && fChk[3:0] <= `SCP_FLAG_MAX
                 && fErr[3:0] <= `SCP_FLAG_MAX;
    else if (isCanCfg)
      fieldsOk = fCan[4] && fCan[3:0] <= `SCP_CAN_RATE_MAX;
    // Priority: header, then overflow or too-short length, then checksum, then length and field values
    if (rxCount == 6'h00 || !(isFrame || isSerCfg || isCanCfg || isRestart))
      next_errCode = `SCP_ERR_HEADER;
    else if (overflow || (checksumEnable && rxCount < `SCP_CHK_CHARS + `SCP_LEN_ONE))
      next_errCode = `SCP_ERR_LENGTH;
    else if (checksumEnable && !(chkHi[4] && chkLo[4] && {chkHi[3:0], chkLo[3:0]} == bodySum))
      next_errCode = `SCP_ERR_CHECKSUM;
    else if (!fieldsOk || bodyLen != wantLen)
      next_errCode = `SCP_ERR_LENGTH;
  end

  // Command buffer with running byte sum; CR is never stored
  always @(posedge core_clk) begin
    if (state == ST_RX && rxValid && rxData != `SCP_CH_CR && rxCount < `SCP_CNT_MAX)
      cmdBuf[rxCount[4:0]] <= rxData;
  end

  // Receive, evaluate and act
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state               <= ST_RX;
      rxCount             <= 6'h00;
      overflow            <= 1'b0;
      runSum              <= 8'h00;
      idleCount           <= 23'h000000;
      errCode             <= 8'h00;
      txValid             <= 1'b0;
      txData              <= 8'h00;
      serialRateCode      <= `SCP_RST_SER_RATE;
      dataBitsCode        <= `SCP_RST_DBITS;
      twoStopBits         <= `SCP_RST_STOP;
      parityMode          <= `SCP_RST_PAR;
      checksumEnable      <= `SCP_RST_CHK;
      errorResponseEnable <= `SCP_RST_ERRRSP;
      canRateCode         <= `SCP_RST_CAN_RATE;
      nvSaveReq           <= 1'b0;
      nvSaveCan           <= 1'b0;
      restartReq          <= 1'b0;
      frameCmdValid       <= 1'b0;
      frameCmdHead        <= 8'h00;
      frameCmdLen         <= 6'h00;
    end else begin
      nvSaveReq     <= 1'b0;
      restartReq    <= 1'b0;
      frameCmdValid <= 1'b0;
      case (state)
        ST_RX: begin
          if (rxValid) begin
            idleCount <= 23'h000000;
            if (rxData == `SCP_CH_CR) begin
              state <= ST_EVAL;
            end else begin
              runSum <= runSum + rxData;
              if (rxCount < `SCP_CNT_MAX)
                rxCount <= rxCount + 6'h01;
              else
                overflow <= 1'b1;
            end
          end else if (rxCount != 6'h00 || overflow) begin
            // Only a started command can time out
            if (idleCount >= TIMEOUT_CYCLES - 23'h000001) begin
              rxCount   <= 6'h00;
              overflow  <= 1'b0;
              runSum    <= 8'h00;
              idleCount <= 23'h000000;
              errCode   <= `SCP_ERR_TIMEOUT;
              if (errorResponseEnable)
                state <= ST_ERRQ;
            end else begin
              idleCount <= idleCount + 23'h000001;
            end
          end
        end
        ST_EVAL: begin
          rxCount  <= 6'h00;
          overflow <= 1'b0;
          runSum   <= 8'h00;
          errCode  <= next_errCode;
          if (next_errCode != 8'h00) begin
            // Rejected: nothing saved, no restart
            state <= errorResponseEnable ? ST_ERRQ : ST_RX;
          end else if (isSerCfg) begin
            serialRateCode      <= fRateLo[3:0];
            dataBitsCode        <= fData[1:0];
            twoStopBits         <= fStop[0];
            parityMode          <= fPar[1:0];
            checksumEnable      <= fChk[0];
            errorResponseEnable <= fErr[0];
            nvSaveReq           <= 1'b1;
            nvSaveCan           <= 1'b0;
            state               <= ST_NV;
          end else if (isCanCfg) begin
            canRateCode <= fCan[2:0];
            nvSaveReq   <= 1'b1;
            nvSaveCan   <= 1'b1;
            state       <= ST_NV;
          end else if (isRestart) begin
            state <= ST_RST;
          end else begin
            // Frame, status and clear commands go on to their own handlers
            frameCmdValid <= 1'b1;
            frameCmdHead  <= cmdBuf[0];
            frameCmdLen   <= bodyLen;
            state         <= ST_RX;
          end
        end
        ST_ERRQ: begin
          if (!txValid) begin
            txValid <= 1'b1;
            txData  <= `SCP_CH_QMARK;
          end else if (txReady) begin
            txValid <= 1'b0;
            state   <= ST_ERRC;
          end
        end
        ST_ERRC: begin
          if (!txValid) begin
            txValid <= 1'b1;
            txData  <= errCode;
          end else if (txReady) begin
            txValid <= 1'b0;
            state   <= ST_ERRR;
          end
        end
        ST_ERRR: begin
          if (!txValid) begin
            txValid <= 1'b1;
            txData  <= `SCP_CH_CR;
          end else if (txReady) begin
            txValid <= 1'b0;
            state   <= ST_RX;
          end
        end
        ST_NV: begin
          // Restart only once the save has finished
          if (nvSaveDone)
            state <= ST_RST;
        end
        ST_RST: begin
          restartReq <= 1'b1;
          state      <= ST_RX;
        end
        default: state <= ST_RX;
      endcase
    end
  end

  // Run indicator: steady on, toggled at a fixed rate while CAN sends fail
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flashCount   <= 23'h000000;
      runIndicator <= 1'b0;
    end else if (!canTxFail) begin
      flashCount   <= 23'h000000;
      runIndicator <= 1'b1;
    end else if (flashCount >= FLASH_CYCLES - 23'h000001) begin
      flashCount   <= 23'h000000;
      runIndicator <= ~runIndicator;
    end else begin
      flashCount <= flashCount + 23'h000001;
    end
  end

endmodule // scp_command_parser
`default_nettype wire

// ### include/scp_defs.vh
// Constants for the serial configuration command parser
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// Characters
`define SCP_CH_CR      8'h0d
`define SCP_CH_QMARK   8'h3f
`define SCP_CH_0       8'h30
`define SCP_CH_1       8'h31
`define SCP_CH_9       8'h39
`define SCP_CH_UA      8'h41
`define SCP_CH_UF      8'h46
`define SCP_CH_LA      8'h61
`define SCP_CH_LF      8'h66
`define SCP_CH_LT      8'h74
`define SCP_CH_UT      8'h54
`define SCP_CH_LE      8'h65
`define SCP_CH_UE      8'h45
`define SCP_CH_US      8'h53
`define SCP_CH_UC      8'h43
`define SCP_CH_UP      8'h50
`define SCP_CH_UR      8'h52
`define SCP_HEX_TEN    4'ha

// Error codes, sent as ASCII digits
`define SCP_ERR_HEADER   8'h31
`define SCP_ERR_LENGTH   8'h32
`define SCP_ERR_CHECKSUM 8'h33
`define SCP_ERR_TIMEOUT  8'h35

// Command buffer and lengths (characters before checksum and CR)
`define SCP_BUF_DEPTH    32
`define SCP_CNT_MAX      6'h20
`define SCP_LEN_STD      6'h05
`define SCP_LEN_EXT      6'h0a
`define SCP_LEN_ONE      6'h01
`define SCP_LEN_RESTART  6'h02
`define SCP_LEN_CANCFG   6'h03
`define SCP_LEN_SERCFG   6'h09
`define SCP_CHK_CHARS    6'h02
`define SCP_POS_DLC_STD  4
`define SCP_POS_DLC_EXT  9
`define SCP_DLC_MAX      4'h8

// Field limits
`define SCP_SER_RATE_MAX 8'h0b
`define SCP_DBITS_MAX    4'h3
`define SCP_STOP_MAX     4'h1
`define SCP_PAR_MAX      4'h2
`define SCP_FLAG_MAX     4'h1
`define SCP_CAN_RATE_MAX 4'h4

// Reset settings: 9600 bps, 8 data, 1 stop, no parity, no checksum, errors on
`define SCP_RST_SER_RATE 4'h7
`define SCP_RST_DBITS    2'h3
`define SCP_RST_STOP     1'h0
`define SCP_RST_PAR      2'h0
`define SCP_RST_CHK      1'h0
`define SCP_RST_ERRRSP   1'h1
`define SCP_RST_CAN_RATE 3'h4

// Timing in 20 MHz core clock cycles: 100 ms receive timeout, 250 ms flash half period
// Kept as sized counts so the 23-bit counters take them without truncation
`define SCP_TIMEOUT_CYC   23'h1e8480
`define SCP_FLASH_CYC     23'h4c4b40

`endif

// ### sim/scp_command_parser_bench.sv
// Self-checking bench for the command parser with a reply and settings model
`timescale 1ns/1ns
`default_nettype none
module scp_command_parser_bench;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        rxValid = 1'b0;
  logic [7:0]  rxData = 8'h00;
  logic        canTxFail = 1'b0;
  wire         txValid, txReady, nvSaveReq, nvSaveCan, nvSaveDone, restartReq;
  wire         twoStopBits, checksumEnable, errorResponseEnable, frameCmdValid, runIndicator;
  wire  [7:0]  txData, frameCmdHead;
  wire  [3:0]  serialRateCode;
  wire  [1:0]  dataBitsCode, parityMode;
  wire  [2:0]  canRateCode;
  wire  [5:0]  frameCmdLen;
  wire  [13:0] cfgSeen = {serialRateCode, dataBitsCode, twoStopBits, parityMode,
                          checksumEnable, errorResponseEnable, canRateCode};
  logic [13:0] cfg = {4'h7, 2'h3, 1'b0, 2'h0, 1'b0, 1'b1, 3'h4};
  int          numErrors = 0, checked = 0, rstCnt = 0, savCnt = 0, frmCnt = 0;
  int          r, rate, d, sb, p, tg;
  logic        lastCan, chkOn = 1'b0, prevRun;
  string       ok = "", e1 = "?1\015", e2 = "?2\015";

  always #25 core_clk = ~core_clk;

  scp_command_parser #(.TIMEOUT_CYCLES(23'h32), .FLASH_CYCLES(23'h8)) u_scp_command_parser (
    .core_clk(core_clk), .reset_n(reset_n), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .serialRateCode(serialRateCode), .dataBitsCode(dataBitsCode), .twoStopBits(twoStopBits),
    .parityMode(parityMode), .checksumEnable(checksumEnable),
    .errorResponseEnable(errorResponseEnable), .canRateCode(canRateCode),
    .nvSaveReq(nvSaveReq), .nvSaveCan(nvSaveCan), .nvSaveDone(nvSaveDone),
    .restartReq(restartReq), .frameCmdValid(frameCmdValid), .frameCmdHead(frameCmdHead),
    .frameCmdLen(frameCmdLen), .canTxFail(canTxFail), .runIndicator(runIndicator));

  scp_host_link u_scp_host_link (
    .core_clk(core_clk), .reset_n(reset_n), .txValid(txValid), .txData(txData),
    .txReady(txReady), .nvSaveReq(nvSaveReq), .nvSaveDone(nvSaveDone));

  // Tally restart and save pulses for the event model
  always @(posedge core_clk) begin
    if (restartReq === 1'b1) rstCnt++;
    if (frameCmdValid === 1'b1) frmCnt++;
    if (nvSaveReq === 1'b1) begin
      savCnt++;
      lastCan = nvSaveCan;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Sends one command, checksum added while the model has it on, then compares results
  task automatic run(input string body, input bit term, input string reply,
                     input int rst, input int sav);
    string s;
    int    i, sum, r0, s0;
    s = body;
    sum = 0;
    for (i = 0; i < body.len(); i++) sum += body[i];
    if (term && chkOn) s = {s, $sformatf("%02X", sum[7:0])};
    if (term) s = {s, "\015"};
    u_scp_host_link.got.delete();
    r0 = rstCnt;
    s0 = savCnt;
    for (i = 0; i < s.len(); i++) begin
      rxValid <= 1'b1;
      rxData  <= s[i];
      @(posedge core_clk);
    end
    rxValid <= 1'b0;
    for (i = 0; i < 400 && (u_scp_host_link.got.size() < reply.len() || rstCnt - r0 < rst); i++)
      @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    check(u_scp_host_link.got.size(), reply.len());
    for (i = 0; i < reply.len() && i < u_scp_host_link.got.size(); i++)
      check(u_scp_host_link.got[i], reply[i]);
    check(rstCnt - r0, rst);
    check(savCnt - s0, sav);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    report_and_stop();
  end

  initial begin
    r = $urandom(32'h96d5);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(cfgSeen, cfg);
    check(runIndicator, 1'b1);
    run("RA", 1, ok, 1, 0);
    run("X1", 1, e1, 0, 0);
    run("P2", 1, e1, 0, 0);
    run("S", 1, ok, 0, 0);
    check(frameCmdHead, 8'h53);
    check(frameCmdLen, 6'h01);
    run("t001512345", 1, e2, 0, 0);
    run("T001", 0, "?5\015", 0, 0);
    // Partial command above must be gone, so these frames decode from a clean buffer
    run("t00150102030405", 1, ok, 0, 0);
    check(frameCmdLen, 6'h0f);
    run("T2E88", 1, ok, 0, 0);
    run("E010156786", 1, ok, 0, 0);
    run("e1234567851122334455", 1, ok, 0, 0);
    check(frameCmdLen, 6'h14);
    run("C", 1, ok, 0, 0);
    check(frmCnt, 6);
    for (r = 0; r < 6; r++) begin
      run($sformatf("P1%0d", r), 1, r < 5 ? ok : e2, r < 5, r < 5);
      if (r < 5) cfg[2:0] = r[2:0];
      check(cfgSeen, cfg);
      check(lastCan, 1'b1);
    end
    // Random serial settings, first one at the top rate code
    for (r = 0; r < 6; r++) begin
      rate = (r == 0) ? 11 : $urandom % 12;
      d = $urandom % 4;
      sb = $urandom % 2;
      p = $urandom % 3;
      run($sformatf("P0%02X%0d%0d%0d01", rate, d, sb, p), 1, ok, 1, 1);
      cfg = {rate[3:0], d[1:0], sb[0], p[1:0], 1'b0, 1'b1, cfg[2:0]};
      check(cfgSeen, cfg);
      check(lastCan, 1'b0);
    end
    run("P00C30001", 1, e2, 0, 0);
    check(cfgSeen, cfg);
    run("P00730011", 1, ok, 1, 1);
    cfg = {4'h7, 2'h3, 1'b0, 2'h0, 1'b1, 1'b1, cfg[2:0]};
    chkOn = 1'b1;
    check(cfgSeen, cfg);
    run("RA", 1, ok, 1, 0);
    chkOn = 1'b0;
    run("RA00", 1, "?3\015", 0, 0);
    chkOn = 1'b1;
    run("P00730000", 1, ok, 1, 1);
    cfg = {4'h7, 2'h3, 1'b0, 2'h0, 1'b0, 1'b0, cfg[2:0]};
    chkOn = 1'b0;
    check(cfgSeen, cfg);
    run("X1", 1, ok, 0, 0);
    canTxFail <= 1'b1;
    tg = 0;
    prevRun = runIndicator;
    repeat (40) begin
      @(posedge core_clk);
      if (runIndicator !== prevRun) tg++;
      prevRun = runIndicator;
    end
    check(tg >= 4, 1'b1);
    canTxFail <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(runIndicator, 1'b1);
    report_and_stop();
  end
endmodule // scp_command_parser_bench

bind scp_command_parser scp_parser_props #(.FLASH_CYCLES(FLASH_CYCLES)) u_scp_parser_props (
  .core_clk(core_clk), .reset_n(reset_n), .txValid(txValid), .txData(txData),
  .txReady(txReady), .serialRateCode(serialRateCode), .parityMode(parityMode),
  .canRateCode(canRateCode), .errorResponseEnable(errorResponseEnable),
  .nvSaveReq(nvSaveReq), .nvSaveCan(nvSaveCan), .restartReq(restartReq),
  .frameCmdValid(frameCmdValid), .frameCmdHead(frameCmdHead), .canTxFail(canTxFail),
  .runIndicator(runIndicator));
`default_nettype wire

// ### sim/scp_host_link.sv
// Host side model: takes reply characters and answers save requests
`timescale 1ns/1ns
`default_nettype none
module scp_host_link (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output var  logic       txReady = 1'b0,
  input  wire logic       nvSaveReq,
  output var  logic       nvSaveDone = 1'b0
);
  logic [7:0] got[$];
  int         busyFor = 0;
  // Sink stalls at random so held reply characters get exercised
  always @(posedge core_clk) begin
    if (reset_n && txValid && txReady) got.push_back(txData);
    txReady <= ($urandom % 3) != 0;
  end
  // Memory write finishes a random few cycles after each request
  always @(posedge core_clk) begin
    nvSaveDone <= (busyFor == 1);
    if (nvSaveReq) busyFor <= 2 + $urandom % 7;
    else if (busyFor != 0) busyFor <= busyFor - 1;
  end
endmodule // scp_host_link
`default_nettype wire

// ### sim/scp_parser_props.sv
// Concurrent checks on the command parser ports
`timescale 1ns/1ns
`default_nettype none
module scp_parser_props #(
  parameter [22:0] FLASH_CYCLES = 23'h8
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       txValid,
  input wire logic [7:0] txData,
  input wire logic       txReady,
  input wire logic [3:0] serialRateCode,
  input wire logic [1:0] parityMode,
  input wire logic [2:0] canRateCode,
  input wire logic       errorResponseEnable,
  input wire logic       nvSaveReq,
  input wire logic       nvSaveCan,
  input wire logic       restartReq,
  input wire logic       frameCmdValid,
  input wire logic [7:0] frameCmdHead,
  input wire logic       canTxFail,
  input wire logic       runIndicator
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [23:0] still;
  logic        prevRun;
  // Cycles the indicator stayed put while transmit fails; too long means no flashing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      still   <= 24'h0;
      prevRun <= 1'b0;
    end else begin
      prevRun <= runIndicator;
      still   <= (canTxFail && runIndicator == prevRun) ? still + 24'h1 : 24'h0;
    end
  end
  property p_hold_reply;
    txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  a_hold_reply: assert property (p_hold_reply)
    else $error("Reply character dropped or changed before acceptance");
  property p_code_after_mark;
    txValid && txReady && txData == 8'h3f |=> !txValid ##1
      (txValid && txData inside {8'h31, 8'h32, 8'h33, 8'h35});
  endproperty
  a_code_after_mark: assert property (p_code_after_mark)
    else $error("Bad error code after question mark");
  property p_cr_after_code;
    txValid && txReady && txData inside {8'h31, 8'h32, 8'h33, 8'h35} |=> !txValid ##1
      (txValid && txData == 8'h0d);
  endproperty
  a_cr_after_code: assert property (p_cr_after_code)
    else $error("Reply not closed by carriage return");
  property p_quiet_errors;
    $rose(txValid) |-> errorResponseEnable;
  endproperty
  a_quiet_errors: assert property (p_quiet_errors)
    else $error("Reply sent while error replies are off");
  property p_save_then_restart;
    nvSaveReq |=> ##[0:40] restartReq;
  endproperty
  a_save_then_restart: assert property (p_save_then_restart)
    else $error("No restart after settings save");
  property p_can_range;
    nvSaveReq && nvSaveCan |-> canRateCode <= 3'h4;
  endproperty
  a_can_range: assert property (p_can_range)
    else $error("CAN rate saved out of range");
  property p_ser_range;
    nvSaveReq && !nvSaveCan |-> serialRateCode <= 4'hb && parityMode != 2'h3;
  endproperty
  a_ser_range: assert property (p_ser_range)
    else $error("Serial settings saved out of range");
  property p_frame_head;
    frameCmdValid |-> frameCmdHead inside {8'h74, 8'h54, 8'h65, 8'h45, 8'h53, 8'h43};
  endproperty
  a_frame_head: assert property (p_frame_head)
    else $error("Unknown header passed on");
  property p_steady_run;
    $past(reset_n) && !$past(canTxFail) |-> runIndicator;
  endproperty
  a_steady_run: assert property (p_steady_run)
    else $error("Run indicator not steady on");
  property p_flash;
    canTxFail |-> still <= FLASH_CYCLES + 23'h2;
  endproperty
  a_flash: assert property (p_flash)
    else $error("Run indicator not flashing");
endmodule // scp_parser_props
`default_nettype wire
